// ### design/dds_pkg.sv
package dds_pkg;

    // Serial word layout, first bit shifted in ends at bit 0
    localparam int WORD_W      = 11;
    localparam int CODE_W      = 9;
    localparam int CHAN_POS    = 0;
    localparam int MODE_POS    = 1;
    localparam int CODE_LSB    = 2;
    localparam int CODE_MAX    = 511;

    // Channel select and path mode encodings
    localparam logic CHAN_A    = 1'b0;
    localparam logic CHAN_B    = 1'b1;
    localparam logic MODE_DUAL = 1'b0;
    localparam logic MODE_EXT  = 1'b1;

    // One code step adds this much delay; modelled in whole clock cycles
    localparam int STEP_PS     = 11;
    localparam int CLK_PS      = 10000;
    localparam int STEP_CYCLES = (STEP_PS + CLK_PS - 1) / CLK_PS;

    // Values after reset
    localparam logic [CODE_W-1:0] CODE_RST = 9'h000;
    localparam logic              MODE_RST = 1'b0;

    // Pin synchroniser lanes
    localparam int SYN_W     = 6;
    localparam int SYN_SCLK  = 0;
    localparam int SYN_SDATA = 1;
    localparam int SYN_LOAD  = 2;
    localparam int SYN_EN_N  = 3;
    localparam int SYN_IN_A  = 4;
    localparam int SYN_IN_B  = 5;
    localparam logic [SYN_W-1:0] SYN_RST = 6'h08;

    typedef struct packed {
        logic pos;
        logic neg;
    } dds_pair_t;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic              mode;
        logic              chan;
    } dds_cfg_word_t;

    // Disabled output pair: true low, complement high
    localparam dds_pair_t PAIR_IDLE = '{pos: 1'b0, neg: 1'b1};

endpackage

// ### design/dds_delay_line.sv
`timescale 1ns/100ps
module dds_delay_line #(
    parameter int CODE_W   = 9,
    parameter int STEP_CYC = 1
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              din_i,
    input  wire logic [CODE_W-1:0] code_i,
    output logic                   dout_o
);
    localparam int DEPTH = ((1 << CODE_W) - 1) * STEP_CYC + 1;

    logic [DEPTH-1:0] taps_reg;
    logic [31:0]      tap_idx;

    generate
        if (CODE_W < 1 || CODE_W > 12 || STEP_CYC < 1) begin : g_chk
            $error("dds_delay_line: unsupported CODE_W or STEP_CYC");
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            taps_reg <= '0;
        end else begin
            taps_reg <= {taps_reg[DEPTH-2:0], din_i};
        end
    end

    assign tap_idx = 32'(code_i) * 32'(STEP_CYC);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_o <= 1'b0;
        end else begin
            dout_o <= taps_reg[tap_idx];
        end
    end

endmodule

// ### design/dds_serial_config.sv
`timescale 1ns/100ps
module dds_serial_config #(
    parameter int CODE_W = dds_pkg::CODE_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              serial_clock_i,
    input  wire logic              serial_data_input_i,
    input  wire logic              load_strobe_i,
    input  wire logic              out_enable_n_i,
    input  wire dds_pkg::dds_pair_t input_pair_a_i,
    input  wire dds_pkg::dds_pair_t input_pair_b_i,
    output dds_pkg::dds_pair_t     output_pair_a_o,
    output dds_pkg::dds_pair_t     output_pair_b_o,
    output logic [CODE_W-1:0]      delay_channel_a_o,
    output logic [CODE_W-1:0]      delay_channel_b_o,
    output logic                   path_mode_bit_o
);
    generate
        if (CODE_W != dds_pkg::CODE_W) begin : g_chk
            $error("dds_serial_config: CODE_W must match the word layout");
        end
    endgenerate

    logic [1:0]                rst_sync_reg;
    logic                      rst_n;
    logic [dds_pkg::SYN_W-1:0] syn1_reg;
    logic [dds_pkg::SYN_W-1:0] syn2_reg;
    logic                      sclk_d_reg;
    logic                      sclk_rise;
    logic                      load_s;
    logic                      en_n_s;
    dds_pkg::dds_cfg_word_t    serial_config_word_reg;
    logic [CODE_W-1:0]         code_a_reg;
    logic [CODE_W-1:0]         code_b_reg;
    logic                      mode_reg;
    logic                      line_b_in;
    logic                      line_a_out;
    logic                      line_b_out;

    function automatic dds_pkg::dds_pair_t drive_pair(input logic off,
                                                      input logic val);
        drive_pair = off ? dds_pkg::PAIR_IDLE
                         : dds_pkg::dds_pair_t'{pos: val, neg: ~val};
    endfunction

    // Reset is released through two flops so all flops leave it together
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Every pin is asynchronous to clk_i; two flops before any logic
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            syn1_reg   <= dds_pkg::SYN_RST;
            syn2_reg   <= dds_pkg::SYN_RST;
            sclk_d_reg <= 1'b0;
        end else begin
            syn1_reg   <= {input_pair_b_i.pos, input_pair_a_i.pos,
                           out_enable_n_i, load_strobe_i,
                           serial_data_input_i, serial_clock_i};
            syn2_reg   <= syn1_reg;
            sclk_d_reg <= syn2_reg[dds_pkg::SYN_SCLK];
        end
    end

    assign sclk_rise = syn2_reg[dds_pkg::SYN_SCLK] & ~sclk_d_reg;
    assign load_s    = syn2_reg[dds_pkg::SYN_LOAD];
    assign en_n_s    = syn2_reg[dds_pkg::SYN_EN_N];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_config_word_reg <= '0;
        end else if (sclk_rise) begin
            serial_config_word_reg <= {syn2_reg[dds_pkg::SYN_SDATA],
                serial_config_word_reg[dds_pkg::WORD_W-1:1]};
        end
    end

    // Latch is transparent for the whole strobe-high time, so a shift
    // during the strobe still reaches it; it freezes on the fall.
    // Transparent latch
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            code_a_reg <= dds_pkg::CODE_RST;
            code_b_reg <= dds_pkg::CODE_RST;
            mode_reg   <= dds_pkg::MODE_RST;
        end else if (load_s) begin
            if (serial_config_word_reg.chan == dds_pkg::CHAN_A) begin
                code_a_reg <= serial_config_word_reg.code;
            end else begin
                code_b_reg <= serial_config_word_reg.code;
            end
            mode_reg <= serial_config_word_reg.mode;
        end
    end

    assign line_b_in = (mode_reg == dds_pkg::MODE_EXT)
                     ? line_a_out
                     : syn2_reg[dds_pkg::SYN_IN_B];

    dds_delay_line #(
        .CODE_W   (CODE_W),
        .STEP_CYC (dds_pkg::STEP_CYCLES)
    ) u_line_a (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .din_i    (syn2_reg[dds_pkg::SYN_IN_A]),
        .code_i   (code_a_reg),
        .dout_o   (line_a_out)
    );

    dds_delay_line #(
        .CODE_W   (CODE_W),
        .STEP_CYC (dds_pkg::STEP_CYCLES)
    ) u_line_b (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .din_i    (line_b_in),
        .code_i   (code_b_reg),
        .dout_o   (line_b_out)
    );

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            output_pair_a_o <= dds_pkg::PAIR_IDLE;
            output_pair_b_o <= dds_pkg::PAIR_IDLE;
        end else begin
            output_pair_a_o <= drive_pair(en_n_s || mode_reg, line_a_out);
            output_pair_b_o <= drive_pair(en_n_s, line_b_out);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            delay_channel_a_o <= dds_pkg::CODE_RST;
            delay_channel_b_o <= dds_pkg::CODE_RST;
            path_mode_bit_o   <= dds_pkg::MODE_RST;
        end else begin
            delay_channel_a_o <= code_a_reg;
            delay_channel_b_o <= code_b_reg;
            path_mode_bit_o   <= mode_reg;
        end
    end

    property p_shift_adv;
        @(posedge clk_i) disable iff (!rst_n)
        sclk_rise |=> serial_config_word_reg[dds_pkg::WORD_W-2:0]
                      == $past(serial_config_word_reg[dds_pkg::WORD_W-1:1]);
    endproperty
    a_shift_adv: assert property (p_shift_adv)
        else $error("word did not shift on serial clock rise");

    property p_load_a;
        @(posedge clk_i) disable iff (!rst_n)
        (load_s && serial_config_word_reg.chan == dds_pkg::CHAN_A)
        |=> code_a_reg == $past(serial_config_word_reg.code)
            && $stable(code_b_reg);
    endproperty
    a_load_a: assert property (p_load_a)
        else $error("channel A load wrong or channel B disturbed");

    property p_load_b;
        @(posedge clk_i) disable iff (!rst_n)
        (load_s && serial_config_word_reg.chan == dds_pkg::CHAN_B)
        |=> code_b_reg == $past(serial_config_word_reg.code)
            && $stable(code_a_reg);
    endproperty
    a_load_b: assert property (p_load_b)
        else $error("channel B load wrong or channel A disturbed");

    property p_mode_load;
        @(posedge clk_i) disable iff (!rst_n)
        load_s |=> mode_reg == $past(serial_config_word_reg.mode);
    endproperty
    a_mode_load: assert property (p_mode_load)
        else $error("mode not taken while strobe high");

    property p_frozen;
        @(posedge clk_i) disable iff (!rst_n)
        !load_s ##1 !load_s |-> $stable(code_a_reg) && $stable(code_b_reg)
                                && $stable(mode_reg);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("latch changed while strobe low");

    property p_ext_idle_a;
        @(posedge clk_i) disable iff (!rst_n)
        mode_reg |=> output_pair_a_o == dds_pkg::PAIR_IDLE;
    endproperty
    a_ext_idle_a: assert property (p_ext_idle_a)
        else $error("pair A not idle in extended mode");

    property p_disable;
        @(posedge clk_i) disable iff (!rst_n)
        en_n_s |=> output_pair_a_o == dds_pkg::PAIR_IDLE
                   && output_pair_b_o == dds_pkg::PAIR_IDLE;
    endproperty
    a_disable: assert property (p_disable)
        else $error("outputs not idle while disabled");

    property p_cascade;
        @(posedge clk_i) disable iff (!rst_n)
        mode_reg |=> u_line_b.taps_reg[0] == $past(line_a_out);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("channel B not fed from channel A");

    property p_dual_b;
        @(posedge clk_i) disable iff (!rst_n)
        (!en_n_s && !mode_reg)
        |=> output_pair_b_o.pos == $past(line_b_out)
            && output_pair_b_o.neg == !$past(line_b_out)
            && output_pair_a_o.pos == $past(line_a_out);
    endproperty
    a_dual_b: assert property (p_dual_b)
        else $error("dual mode output mismatch");

endmodule

// ### tb/dds_ctrl_model.sv
`timescale 1ns/100ps
module dds_ctrl_model (
    output logic serial_clock_o,
    output logic serial_data_o,
    output logic load_strobe_o,
    output logic out_enable_n_o
);
    initial begin
        serial_clock_o = 1'b0;
        serial_data_o  = 1'b0;
        load_strobe_o  = 1'b0;
        out_enable_n_o = 1'b0;
    end

    // Call just after a system clock edge; serial period is 80 ns
    task automatic send(input dds_pkg::dds_cfg_word_t w, input logic strobe);
        logic [10:0] bits;
        bits = w;
        out_enable_n_o = 1'b1;
        for (int i = 0; i < 11; i++) begin
            serial_data_o = bits[i];
            #40 serial_clock_o = 1'b1;
            #40 serial_clock_o = 1'b0;
        end
        // Released data line shows the inverse, never a stale copy
        serial_data_o = ~bits[10];
        if (strobe) begin
            #40 load_strobe_o = 1'b1;
            #80 load_strobe_o = 1'b0;
        end
        #40 out_enable_n_o = 1'b0;
    endtask

    task automatic set_en_n(input logic v);
        out_enable_n_o = v;
    endtask
endmodule

// ### tb/dds_serial_config_test.sv
`timescale 1ns/100ps
module dds_serial_config_test;
    logic               clk_i;
    logic               rst_n_i;
    logic               sclk, sdata, load_strobe, en_n;
    dds_pkg::dds_pair_t in_a, in_b, out_a, out_b;
    logic [8:0]         code_a, code_b;
    logic               mode;
    int                 n_mismatch = 0;
    int                 compares = 0;
    int                 cycles = 0;
    int                 n;

    dds_serial_config i_dds_serial_config (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .serial_clock_i(sclk), .serial_data_input_i(sdata),
        .load_strobe_i(load_strobe), .out_enable_n_i(en_n),
        .input_pair_a_i(in_a), .input_pair_b_i(in_b),
        .output_pair_a_o(out_a), .output_pair_b_o(out_b),
        .delay_channel_a_o(code_a), .delay_channel_b_o(code_b),
        .path_mode_bit_o(mode));

    dds_ctrl_model i_dds_ctrl_model (
        .serial_clock_o(sclk), .serial_data_o(sdata),
        .load_strobe_o(load_strobe), .out_enable_n_o(en_n));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Whole run needs about 1750 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic load(input logic ch, input logic md, input logic [8:0] c,
                        input logic strobe);
        @(posedge clk_i);
        #1;
        i_dds_ctrl_model.send('{code: c, mode: md, chan: ch}, strobe);
        repeat (8) @(posedge clk_i);
        #1;
    endtask

    // Cycles from an input rise to the chosen output rise
    task automatic edge_delay(input logic b_in, input logic b_out,
                              output int cnt);
        cnt = 0;
        @(posedge clk_i);
        #1;
        if (b_in)
            in_b = '{pos: 1'b1, neg: 1'b0};
        else
            in_a = '{pos: 1'b1, neg: 1'b0};
        while (cnt < 1200 && (b_out ? out_b.pos : out_a.pos) !== 1'b1) begin
            @(posedge clk_i);
            #1;
            cnt++;
        end
        in_a = dds_pkg::PAIR_IDLE;
        in_b = dds_pkg::PAIR_IDLE;
        repeat (cnt + 8) @(posedge clk_i);
        #1;
    endtask

    task automatic t_shift_only();
        load(1'b1, 1'b1, 9'h1a5, 1'b0);
        chk(32'(code_a), 32'h0);
        chk(32'(code_b), 32'h0);
        chk(32'(mode), 32'h0);
        edge_delay(1'b0, 1'b0, n);
        chk(n, 32'h5);
    endtask

    task automatic t_dual();
        load(1'b0, 1'b0, 9'h005, 1'b1);
        chk(32'(code_a), 32'h5);
        load(1'b1, 1'b0, 9'h1ff, 1'b1);
        chk(32'(code_b), 32'h1ff);
        chk(32'(code_a), 32'h5);
        edge_delay(1'b0, 1'b0, n);
        chk(n, 32'ha);
        edge_delay(1'b1, 1'b1, n);
        chk(n, 32'h204);
    endtask

    task automatic t_freeze();
        load(1'b0, 1'b1, 9'h0aa, 1'b0);
        chk(32'(code_a), 32'h5);
        chk(32'(code_b), 32'h1ff);
        chk(32'(mode), 32'h0);
    endtask

    task automatic t_ext();
        load(1'b1, 1'b1, 9'h003, 1'b1);
        chk(32'(mode), 32'h1);
        chk(32'(code_a), 32'h5);
        chk(32'(code_b), 32'h3);
        edge_delay(1'b0, 1'b1, n);
        chk(n, 32'hf);
        in_a = '{pos: 1'b1, neg: 1'b0};
        repeat (20) @(posedge clk_i);
        #1;
        chk(32'(out_a), 32'(dds_pkg::PAIR_IDLE));
        chk(32'(out_b), 32'h2);
    endtask

    task automatic t_enable();
        i_dds_ctrl_model.set_en_n(1'b1);
        in_b = '{pos: 1'b1, neg: 1'b0};
        repeat (20) @(posedge clk_i);
        #1;
        chk(32'(out_a), 32'(dds_pkg::PAIR_IDLE));
        chk(32'(out_b), 32'(dds_pkg::PAIR_IDLE));
        i_dds_ctrl_model.set_en_n(1'b0);
        repeat (20) @(posedge clk_i);
        #1;
        chk(32'(out_b), 32'h2);
    endtask

    initial begin
        rst_n_i = 1'b0;
        in_a = dds_pkg::PAIR_IDLE;
        in_b = dds_pkg::PAIR_IDLE;
        repeat (10) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (5) @(posedge clk_i);
        t_shift_only();
        t_dual();
        t_freeze();
        t_ext();
        t_enable();
        final_report();
    end
endmodule
